// ---- core/fplt_pkg.sv ----
package fplt_pkg;
  // Special-function register addresses.
  localparam logic [7:0] ADDR_TIMING_SCALE = 8'hb6;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hb7;
  localparam logic [7:0] ADDR_CACHE_CONTROL = 8'he3;
  // Key values.
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  // Field positions.
  localparam int BIT_READ_STRETCH = 4;
  localparam int BIT_EXT_TIMING = 1;
  localparam int BIT_PREFETCH = 5;
  localparam int BIT_PAIRED = 0;
  // Values after reset.
  localparam logic [7:0] RST_TIMING_SCALE = 8'h00;
  localparam logic [7:0] RST_CACHE_CONTROL = 8'h20;
  // Writable bit masks.
  localparam logic [7:0] MASK_TIMING_SCALE = 8'h12;
  localparam logic [7:0] MASK_CACHE_CONTROL = 8'h21;
  // Read strobe lengths in cycles.
  localparam logic [1:0] STROBE_SHORT = 2'h1;
  localparam logic [1:0] STROBE_LONG = 2'h2;
  // Lock states, binary order along the usual path; codes are the read value.
  typedef enum logic [1:0] {
    FPLT_LOCKED = 2'h0,
    FPLT_FIRST = 2'h1,
    FPLT_OPEN = 2'h2,
    FPLT_DEAD = 2'h3
  } fplt_lock_e;
endpackage

// ---- core/fplt_strobe.sv ----
module fplt_strobe (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Read request and length select.
  input wire logic rd_req,
  input wire logic stretch,
  // Strobe to the array.
  output logic rd_strobe,
  output logic rd_done
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // Loads the strobe length on a request and counts it down.
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (cnt_r != 2'h0) begin
      cnt_nxt = cnt_r - 2'h1;
      done_nxt = (cnt_r == 2'h1);
    end else if (rd_req) begin
      cnt_nxt = stretch ? fplt_pkg::STROBE_LONG : fplt_pkg::STROBE_SHORT;
    end
  end

  // Registers the counter.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  // The strobe is high while the counter runs.
  assign rd_strobe = (cnt_r != 2'h0);
  assign rd_done = done_r;
endmodule

// ---- core/fplt_top.sv ----
// Behaviour
// - Key A5 then F1 unlocks flash changes.
// - Permission withdrawn after one write or erase.
// - Wrong key write locks until reset.
// - Attempt while locked is suppressed, locks hard.
// - Key read returns lock state low bits.
// - Read strobe one or two clocks.
// - Timing bit picks short or extended timing.
// - Paired-write bit groups bytes in twos.
// - Prefetch bit switches prefetch engine.
module fplt_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Special-function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Flash operation requests from the core.
  input wire logic op_req,
  input wire logic op_erase,
  input wire logic op_busy,
  input wire logic rd_req,
  // Flash controller outputs.
  output logic op_start,
  output logic op_start_erase,
  output logic op_suppressed,
  output logic rd_strobe,
  output logic rd_done,
  output logic extended_program_timing,
  output logic prefetch_enable,
  output logic paired_byte_write,
  output logic pair_commit,
  output logic [1:0] lock_state
);
  fplt_pkg::fplt_lock_e lock_r;
  fplt_pkg::fplt_lock_e lock_nxt;
  logic [7:0] scale_r;
  logic [7:0] scale_nxt;
  logic [7:0] cache_r;
  logic [7:0] cache_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic busy_seen_r;
  logic busy_seen_nxt;
  logic pend_r;
  logic pend_nxt;
  logic start_r;
  logic start_nxt;
  logic erase_r;
  logic erase_nxt;
  logic supp_r;
  logic supp_nxt;
  logic pair_r;
  logic pair_nxt;
  logic key_wr;

  // Compares a port address with one register address, for writes and reads.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign key_wr = sfr_wr && hit(sfr_addr, fplt_pkg::ADDR_UNLOCK_KEY);

  // Lock state machine and operation gating.
  always_comb begin
    lock_nxt = lock_r;
    busy_seen_nxt = busy_seen_r;
    pend_nxt = pend_r;
    start_nxt = 1'b0;
    erase_nxt = erase_r;
    supp_nxt = 1'b0;
    pair_nxt = 1'b0;
    unique case (lock_r)
      fplt_pkg::FPLT_LOCKED: begin
        if (key_wr) begin
          if (sfr_wdata == fplt_pkg::KEY_FIRST) begin
            lock_nxt = fplt_pkg::FPLT_FIRST;
          end else begin
            lock_nxt = fplt_pkg::FPLT_DEAD;
          end
        end
      end
      fplt_pkg::FPLT_FIRST: begin
        if (key_wr) begin
          if (sfr_wdata == fplt_pkg::KEY_SECOND) begin
            lock_nxt = fplt_pkg::FPLT_OPEN;
          end else begin
            lock_nxt = fplt_pkg::FPLT_DEAD;
          end
        end
      end
      fplt_pkg::FPLT_OPEN: begin
        if (key_wr) begin
          lock_nxt = fplt_pkg::FPLT_DEAD;
        end
      end
      fplt_pkg::FPLT_DEAD: begin
        lock_nxt = fplt_pkg::FPLT_DEAD;
      end
    endcase
    // A request while not open is dropped and locks hard.
    if (op_req && !pend_r) begin
      if (lock_r == fplt_pkg::FPLT_OPEN && !key_wr) begin
        if (op_erase || !cache_r[fplt_pkg::BIT_PAIRED] || pair_r) begin
          start_nxt = 1'b1;
          erase_nxt = op_erase;
          pend_nxt = 1'b1;
          busy_seen_nxt = 1'b0;
        end else begin
          pair_nxt = 1'b1;
        end
      end else begin
        supp_nxt = 1'b1;
        lock_nxt = fplt_pkg::FPLT_DEAD;
      end
    end else if (pair_r) begin
      pair_nxt = 1'b1;
    end
    // Relock after the started operation has run to completion.
    if (pend_r) begin
      if (op_busy) begin
        busy_seen_nxt = 1'b1;
      end else if (busy_seen_r) begin
        pend_nxt = 1'b0;
        if (lock_nxt == fplt_pkg::FPLT_OPEN) begin
          lock_nxt = fplt_pkg::FPLT_LOCKED;
        end
      end
    end
  end

  // Control registers and read data.
  always_comb begin
    scale_nxt = scale_r;
    cache_nxt = cache_r;
    rdata_nxt = rdata_r;
    if (sfr_wr && hit(sfr_addr, fplt_pkg::ADDR_TIMING_SCALE)) begin
      scale_nxt = sfr_wdata & fplt_pkg::MASK_TIMING_SCALE;
    end
    if (sfr_wr && hit(sfr_addr, fplt_pkg::ADDR_CACHE_CONTROL)) begin
      cache_nxt = sfr_wdata & fplt_pkg::MASK_CACHE_CONTROL;
    end
    if (sfr_rd) begin
      if (hit(sfr_addr, fplt_pkg::ADDR_UNLOCK_KEY)) begin
        rdata_nxt = {6'h00, lock_r};
      end else if (hit(sfr_addr, fplt_pkg::ADDR_TIMING_SCALE)) begin
        rdata_nxt = scale_r;
      end else if (hit(sfr_addr, fplt_pkg::ADDR_CACHE_CONTROL)) begin
        rdata_nxt = cache_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Registers all state.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_r <= fplt_pkg::FPLT_LOCKED;
      scale_r <= fplt_pkg::RST_TIMING_SCALE;
      cache_r <= fplt_pkg::RST_CACHE_CONTROL;
      rdata_r <= 8'h00;
      busy_seen_r <= 1'b0;
      pend_r <= 1'b0;
      start_r <= 1'b0;
      erase_r <= 1'b0;
      supp_r <= 1'b0;
      pair_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      scale_r <= scale_nxt;
      cache_r <= cache_nxt;
      rdata_r <= rdata_nxt;
      busy_seen_r <= busy_seen_nxt;
      pend_r <= pend_nxt;
      start_r <= start_nxt;
      erase_r <= erase_nxt;
      supp_r <= supp_nxt;
      pair_r <= pair_nxt;
    end
  end

  // Read strobe generator.
  fplt_strobe u_strobe (
    .clk(clk),
    .rstn(rstn),
    .rd_req(rd_req),
    .stretch(scale_r[fplt_pkg::BIT_READ_STRETCH]),
    .rd_strobe(rd_strobe),
    .rd_done(rd_done)
  );

  // Outputs from registers.
  assign sfr_rdata = rdata_r;
  assign op_start = start_r;
  assign op_start_erase = start_r && erase_r;
  assign op_suppressed = supp_r;
  assign extended_program_timing = scale_r[fplt_pkg::BIT_EXT_TIMING];
  assign prefetch_enable = cache_r[fplt_pkg::BIT_PREFETCH];
  assign paired_byte_write = cache_r[fplt_pkg::BIT_PAIRED];
  assign pair_commit = pair_r;
  assign lock_state = lock_r;
endmodule

// ---- tb/fplt_checker.sv ----
module fplt_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Controller outputs.
  input wire logic op_start,
  input wire logic op_suppressed,
  input wire logic rd_strobe,
  input wire logic rd_done,
  input wire logic [1:0] lock_state
);
  // Every check samples on the rising edge outside reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic kw;
  // A key write is a register write to the key address.
  assign kw = sfr_wr && sfr_addr == 8'hb7;
  a_first_key: assert property (kw && sfr_wdata == 8'ha5
    && lock_state == 2'h0 |=> lock_state == 2'h1) else $error("first key");
  a_second_key: assert property (kw && sfr_wdata == 8'hf1
    && lock_state == 2'h1 |=> lock_state == 2'h2) else $error("second key");
  a_bad_key: assert property (kw
    && !(lock_state == 2'h0 && sfr_wdata == 8'ha5)
    && !(lock_state == 2'h1 && sfr_wdata == 8'hf1)
    |=> lock_state == 2'h3) else $error("bad key not locked");
  a_dead_sticks: assert property (lock_state == 2'h3
    |=> lock_state == 2'h3) else $error("hard lock lifted");
  a_drop_locks: assert property (op_suppressed
    |-> lock_state == 2'h3) else $error("drop without lock");
  a_start_open: assert property (op_start
    |-> $past(lock_state) == 2'h2) else $error("start while locked");
  a_lock_read: assert property (sfr_rd && sfr_addr == 8'hb7
    |=> sfr_rdata == {6'h00, $past(lock_state)}) else $error("key read");
  a_strobe_end: assert property ($rose(rd_strobe)
    |=> ##[0:1] (!rd_strobe && rd_done)) else $error("strobe length");
  a_done_after: assert property (rd_done
    |-> !rd_strobe && $past(rd_strobe)) else $error("done early");
  // Main scenarios reached.
  c_open: cover property (lock_state == 2'h2);
  c_drop: cover property (op_suppressed);
  c_long: cover property (rd_strobe [*2]);
endmodule

bind fplt_top fplt_checker chk_u (.clk, .rstn, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rd, .sfr_rdata, .op_start, .op_suppressed, .rd_strobe,
  .rd_done, .lock_state);

// ---- tb/fplt_tb_top.sv ----
module fplt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0;
  logic op_req = 0, op_erase = 0, op_busy = 0, rd_req = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic op_start, op_start_erase, op_suppressed, rd_strobe, rd_done;
  logic extended_program_timing, prefetch_enable, paired_byte_write;
  logic pair_commit;
  logic [1:0] lock_state;
  int fail_count = 0;
  int n_compared = 0;
  // Clock at 125 MHz.
  initial begin
    forever #4 clk = ~clk;
  end
  fplt_top dut_u (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .op_req, .op_erase, .op_busy, .rd_req, .op_start,
    .op_start_erase, .op_suppressed, .rd_strobe, .rd_done,
    .extended_program_timing, .prefetch_enable, .paired_byte_write,
    .pair_commit, .lock_state);
  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Holds reset for five cycles.
  task automatic do_reset();
    rstn = 0;
    repeat (5) @(negedge clk);
    rstn = 1;
  endtask
  // One register write.
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge clk);
    sfr_wr = 0;
  endtask
  // One register read, judged once the data has landed.
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    @(negedge clk);
    sfr_rd = 0;
    chk("rdata", sfr_rdata, e);
  endtask
  // One cycle operation request.
  task automatic op(input logic er);
    @(negedge clk);
    {op_req, op_erase} = {1'b1, er};
    @(negedge clk);
    op_req = 0;
  endtask
  // Counts strobe cycles of one flash read.
  task automatic strobe(input logic [7:0] e);
    int n;
    int d;
    n = 0;
    d = 0;
    @(negedge clk);
    rd_req = 1;
    @(negedge clk);
    rd_req = 0;
    repeat (4) begin
      n += rd_strobe;
      d += rd_done;
      @(negedge clk);
    end
    chk("strobe", n[7:0], e);
    chk("done", d[7:0], 1);
  endtask
  // Values after reset, plus an unmapped read.
  task automatic t_reset_vals();
    rd(8'hb6, 8'h00);
    rd(8'he3, 8'h20);
    rd(8'hb7, 8'h00);
    rd(8'h00, 8'h00);
    chk("ext", extended_program_timing, 0);
    chk("prefetch", prefetch_enable, 1);
  endtask
  // Unlock, one erase, relock, then a dropped attempt.
  task automatic t_unlock_op();
    wr(8'hb6, 8'h02);
    chk("ext", extended_program_timing, 1);
    wr(8'hb7, 8'ha5);
    rd(8'hb7, 8'h01);
    wr(8'hb7, 8'hf1);
    rd(8'hb7, 8'h02);
    op(1);
    chk("start", {op_start, op_start_erase}, 3);
    op_busy = 1;
    repeat (3) @(negedge clk);
    op_busy = 0;
    repeat (3) @(negedge clk);
    chk("relock", lock_state, 0);
    op(0);
    chk("drop", {op_start, op_suppressed, lock_state}, 7);
    wr(8'hb7, 8'ha5);
    chk("dead", lock_state, 3);
    do_reset();
    chk("reset", lock_state, 0);
  endtask
  // Wrong second key, and a deliberate lock.
  task automatic t_bad_key();
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'ha5);
    rd(8'hb7, 8'h03);
    do_reset();
    wr(8'hb7, 8'h5a);
    rd(8'hb7, 8'h03);
    do_reset();
  endtask
  // Paired byte writes, then a key write while open.
  task automatic t_paired();
    wr(8'he3, 8'h01);
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'hf1);
    op(0);
    chk("pair1", {op_start, pair_commit, lock_state}, 6);
    op(0);
    chk("pair2", {op_start, pair_commit, lock_state}, 10);
    op_busy = 1;
    repeat (2) @(negedge clk);
    op_busy = 0;
    repeat (2) @(negedge clk);
    chk("relock", lock_state, 0);
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'hf1);
    wr(8'hb7, 8'hf1);
    rd(8'hb7, 8'h03);
    do_reset();
  endtask
  // Strobe lengths, masks and cache bits.
  task automatic t_strobe_cache();
    strobe(1);
    wr(8'hb6, 8'hff);
    rd(8'hb6, 8'h12);
    strobe(2);
    wr(8'he3, 8'hff);
    rd(8'he3, 8'h21);
    chk("cache", {prefetch_enable, paired_byte_write}, 3);
    wr(8'he3, 8'h00);
    chk("cache", {prefetch_enable, paired_byte_write}, 0);
  endtask
  // Prints the counts and the verdict.
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    do_reset();
    t_reset_vals();
    t_unlock_op();
    t_bad_key();
    t_paired();
    t_strobe_cache();
    final_report();
  end
endmodule
